// ==== core/smsp_status_protect.sv ====
// Status register and write protection of a serial memory
// How it works
// - After the read-status opcode, status byte shifts out next.
// - Status bits 0, 4, 5 and 6 always read as zero.
// - Reading status changes no bit, not even the write latch.
// - Write latch in bit 1 gates every array and status write.
// - Bits 2 and 3 hold block guard values, cleared to 00 at reset.
// - Guard 00 none, 01 600-7FF, 10 400-7FF, 11 whole array.
// - Unguarded byte written only with latch set; guarded never.
// - Write-status updates guard and enable bits and clears latch on the same clock.
// - Enable bit 7 high and guard pin low blocks status writes.
// - Write latch clears at power-up, so all starts protected.
// - Opcodes: set latch 06, read status 05, write status 01.
// - Every serial byte moves most significant bit first.
`timescale 1ns/10ps
`default_nettype none
module smsp_status_protect
  import smsp_pkg::*;
#(
  parameter int ADDR_W = 11
) (
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic              sck,
  input  wire logic              cs_b,
  input  wire logic              si,
  input  wire logic              wp_b,
  input  wire logic [ADDR_W-1:0] array_addr,
  input  wire logic              array_wr_req,
  output logic                   so,
  output logic                   so_oe,
  output logic                   array_wr_allow,
  output logic [7:0]             status_value
);
  smsp_sync_if sync ();

  smsp_sync u_sync (
    .clock    (clock),
    .rst_b    (rst_b),
    .sck_pin  (sck),
    .cs_b_pin (cs_b),
    .si_pin   (si),
    .wp_b_pin (wp_b),
    .sync     (sync)
  );

  smsp_state_t state_r;
  smsp_state_t state_nxt;
  logic        sck_prev_r;
  logic [2:0]  bit_cnt_r;
  logic [6:0]  shift_r;
  logic [7:0]  out_r;
  logic        latch_r;
  logic [1:0]  guard_r;
  logic        hw_en_r;
  logic        so_r;
  logic        so_oe_r;
  logic        wr_allow_r;
  logic [7:0]  status_r;

  wire       rise     = sync.sck & ~sck_prev_r;
  wire       fall     = ~sync.sck & sck_prev_r;
  wire       selected = ~sync.cs_b;
  wire       byte_end = rise & (bit_cnt_r == SMSP_BIT_COUNT_LAST);
  wire [7:0] rx_byte  = {shift_r, sync.si};

  function automatic logic [7:0] status_image(input logic en,
                                              input logic [1:0] g,
                                              input logic wl);
    logic [7:0] v;
    v = 8'h00;
    v[SMSP_BIT_HW_GUARD_EN] = en;
    v[SMSP_BIT_GUARD_HIGH]  = g[1];
    v[SMSP_BIT_GUARD_LOW]   = g[0];
    v[SMSP_BIT_WRITE_LATCH] = wl;
    return v;
  endfunction

  function automatic logic guarded(input logic [1:0] g,
                                   input logic [ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    unique case (g)
      2'b00: hit = 1'b0;
      2'b01: hit = a >= ADDR_W'(SMSP_GUARD_QUARTER_BASE);
      2'b10: hit = a >= ADDR_W'(SMSP_GUARD_HALF_BASE);
      2'b11: hit = a >= ADDR_W'(SMSP_GUARD_ALL_BASE);
    endcase
    return hit;
  endfunction

  // Status writes need the latch and must not be pin-locked
  wire status_wr_ok = latch_r & ~(hw_en_r & ~sync.wp_b);
  wire op_set   = rx_byte == SMSP_OP_SET_WRITE_LATCH;
  wire op_clr   = rx_byte == SMSP_OP_CLEAR_LATCH;
  wire op_read  = rx_byte == SMSP_OP_READ_STATUS;
  wire op_write = rx_byte == SMSP_OP_WRITE_STATUS;
  wire wstat_done = (state_r == SMSP_ST_WSTAT) & byte_end;
  wire wstat_take = wstat_done & status_wr_ok;

  always_comb begin
    state_nxt = state_r;
    if (byte_end) begin
      unique case (state_r)
        SMSP_ST_OPCODE: begin
          if (op_read) begin
            state_nxt = SMSP_ST_STATUS;
          end else if (op_write) begin
            state_nxt = SMSP_ST_WSTAT;
          end else begin
            state_nxt = SMSP_ST_IGNORE;
          end
        end
        SMSP_ST_STATUS: state_nxt = SMSP_ST_STATUS;
        SMSP_ST_WSTAT:  state_nxt = SMSP_ST_IGNORE;
        SMSP_ST_IGNORE: state_nxt = SMSP_ST_IGNORE;
      endcase
    end
  end

  // Frame control: deselect returns to opcode and floats the output
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r    <= SMSP_ST_OPCODE;
      // Matches the synchroniser preload, so no false rise after reset
      sck_prev_r <= 1'b1;
      bit_cnt_r  <= 3'h0;
      shift_r    <= 7'h00;
    end else begin
      sck_prev_r <= sync.sck;
      if (!selected) begin
        state_r   <= SMSP_ST_OPCODE;
        bit_cnt_r <= 3'h0;
      end else begin
        state_r <= state_nxt;
        if (rise) begin
          bit_cnt_r <= bit_cnt_r + 3'h1;
          shift_r   <= rx_byte[6:0];
        end
      end
    end
  end

  // Latch cleared at reset; set wins only on its own opcode
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      latch_r <= 1'b0;
      guard_r <= SMSP_GUARD_RESET;
      hw_en_r <= SMSP_HW_GUARD_RESET;
    end else if (selected && state_r == SMSP_ST_OPCODE && byte_end) begin
      if (op_set) begin
        latch_r <= 1'b1;
      end else if (op_clr) begin
        latch_r <= 1'b0;
      end
    end else if (wstat_done) begin
      latch_r <= 1'b0;
      if (wstat_take) begin
        guard_r <= {rx_byte[SMSP_BIT_GUARD_HIGH],
                    rx_byte[SMSP_BIT_GUARD_LOW]};
        hw_en_r <= rx_byte[SMSP_BIT_HW_GUARD_EN];
      end
    end
  end

  // Status shifts out MSB first; falling edges advance it
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      out_r   <= 8'h00;
      so_r    <= 1'b0;
      so_oe_r <= 1'b0;
    end else if (!selected) begin
      so_oe_r <= 1'b0;
    end else if (state_r == SMSP_ST_OPCODE && byte_end && op_read) begin
      out_r   <= status_image(hw_en_r, guard_r, latch_r);
    end else if (state_r == SMSP_ST_STATUS && fall) begin
      so_r    <= out_r[7];
      so_oe_r <= 1'b1;
      out_r   <= {out_r[6:0], out_r[7]};
    end
  end

  // Array write permission for the outside datapath
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_allow_r <= 1'b0;
    end else begin
      wr_allow_r <= array_wr_req & latch_r
                    & ~guarded(guard_r, array_addr);
    end
  end

  // Visible status image, registered so the port comes from a flop;
  // it trails the internal bits by one clock
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      status_r <= 8'h00;
    end else begin
      status_r <= status_image(hw_en_r, guard_r, latch_r);
    end
  end

  assign so             = so_r;
  assign so_oe          = so_oe_r;
  assign array_wr_allow = wr_allow_r;
  assign status_value   = status_r;
endmodule
`default_nettype wire

// ==== core/smsp_pkg.sv ====
// Package: opcodes, status layout, guard ranges and reset values
package smsp_pkg;
  localparam logic [7:0]  SMSP_OP_SET_WRITE_LATCH = 8'h06;
  localparam logic [7:0]  SMSP_OP_CLEAR_LATCH     = 8'h04;
  localparam logic [7:0]  SMSP_OP_READ_STATUS     = 8'h05;
  localparam logic [7:0]  SMSP_OP_WRITE_STATUS    = 8'h01;
  localparam int          SMSP_BIT_WRITE_LATCH    = 1;
  localparam int          SMSP_BIT_GUARD_LOW      = 2;
  localparam int          SMSP_BIT_GUARD_HIGH     = 3;
  localparam int          SMSP_BIT_HW_GUARD_EN    = 7;
  localparam logic [1:0]  SMSP_GUARD_RESET        = 2'h0;
  localparam logic        SMSP_HW_GUARD_RESET     = 1'h0;
  localparam logic [10:0] SMSP_GUARD_QUARTER_BASE = 11'h600;
  localparam logic [10:0] SMSP_GUARD_HALF_BASE    = 11'h400;
  localparam logic [10:0] SMSP_GUARD_ALL_BASE     = 11'h000;
  localparam logic [2:0]  SMSP_BIT_COUNT_LAST     = 3'h7;

  typedef enum logic [1:0] {
    SMSP_ST_OPCODE = 2'b00,
    SMSP_ST_STATUS = 2'b01,
    SMSP_ST_WSTAT  = 2'b10,
    SMSP_ST_IGNORE = 2'b11
  } smsp_state_t;
endpackage

// ==== core/smsp_sync_if.sv ====
// Interface carrying synchronised serial-link levels
`timescale 1ns/10ps
`default_nettype none
interface smsp_sync_if;
  logic sck;
  logic cs_b;
  logic si;
  logic wp_b;
  modport src (output sck, output cs_b, output si, output wp_b);
  modport dst (input sck, input cs_b, input si, input wp_b);
endinterface
`default_nettype wire

// ==== core/smsp_sync.sv ====
// Two-flop synchronisers for the serial-link pins
`timescale 1ns/10ps
`default_nettype none
module smsp_sync (
  input  wire logic   clock,
  input  wire logic   rst_b,
  input  wire logic   sck_pin,
  input  wire logic   cs_b_pin,
  input  wire logic   si_pin,
  input  wire logic   wp_b_pin,
  smsp_sync_if.src    sync
);
  logic [3:0] meta_r;
  logic [3:0] stable_r;

  // Deselected idle levels so no false frame starts at reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta_r   <= 4'hb;
      stable_r <= 4'hb;
    end else begin
      meta_r   <= {wp_b_pin, si_pin, cs_b_pin, sck_pin};
      stable_r <= meta_r;
    end
  end

  assign sync.sck  = stable_r[0];
  assign sync.cs_b = stable_r[1];
  assign sync.si   = stable_r[2];
  assign sync.wp_b = stable_r[3];
endmodule
`default_nettype wire

// ==== sim/smsp_status_protect_props.sv ====
// Checker of status and write-protect behaviour
`timescale 1ns/10ps
`default_nettype none
module smsp_status_protect_chk
  import smsp_pkg::*;
#(
  parameter int ADDR_W = 11
) (
  input wire logic              clock,
  input wire logic              rst_b,
  input wire logic              cs_b,
  input wire logic              wp_b,
  input wire logic [ADDR_W-1:0] array_addr,
  input wire logic              array_wr_req,
  input wire logic              so_oe,
  input wire logic              array_wr_allow,
  input wire logic [7:0]        status_value
);
  wire logic [1:0] grd = status_value[3:2];
  wire logic       wl = status_value[1];
  wire logic       prot = grd == 2'h3 ||
    (grd == 2'h2 && array_addr >= SMSP_GUARD_HALF_BASE) ||
    (grd == 2'h1 && array_addr >= SMSP_GUARD_QUARTER_BASE);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Six idle clocks outlast the synchroniser lag
  sequence cs_idle;
    cs_b [*6];
  endsequence
  unused_zero_a: assert property ((status_value & 8'h71) == 8'h00)
    else $error("unused bit set");
  latch_reset_a: assert property ($rose(rst_b) |-> !wl)
    else $error("latch set at reset");
  allow_cause_a: assert property (array_wr_allow |->
    $past(array_wr_req && wl && !prot)) else $error("bad allow");
  allow_grant_a: assert property (array_wr_req && wl && !prot |=>
    array_wr_allow) else $error("allow missing");
  guard_lock_a: assert property (!wl |=>
    $stable({status_value[7], grd})) else $error("write without latch");
  hw_lock_a: assert property ((status_value[7] && !wp_b) [*4] |=>
    $stable({status_value[7], grd})) else $error("write while locked");
  status_hold_a: assert property (cs_idle |=> $stable(status_value))
    else $error("status moved while idle");
  so_idle_a: assert property (cs_idle |-> !so_oe)
    else $error("output driven while idle");
endmodule
bind smsp_status_protect smsp_status_protect_chk #(.ADDR_W(ADDR_W)) chk_i (
  .clock(clock), .rst_b(rst_b), .cs_b(cs_b), .wp_b(wp_b),
  .array_addr(array_addr), .array_wr_req(array_wr_req), .so_oe(so_oe),
  .array_wr_allow(array_wr_allow), .status_value(status_value));
`default_nettype wire

// ==== sim/smsp_host_model.sv ====
// Host model: serial master framing bytes
`timescale 1ns/10ps
`default_nettype none
module smsp_host_model (
  output logic     sck,
  output logic     cs_b,
  output logic     si,
  input wire logic so
);
  // Clock rests high between frames
  initial begin
    sck = 1'b1;
    cs_b = 1'b1;
    si = 1'b0;
  end
  task automatic frame(input logic [7:0] op, input logic [7:0] wr,
                       input int bits, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {op, wr};
    #17 cs_b = 1'b0;
    #240;
    for (int i = 15; i > 15 - bits; i--) begin
      sck = 1'b0;
      si = sh[i];
      #40 rd[i % 8] = so;
      sck = 1'b1;
      #40;
    end
    // Released data line must not keep its last level
    si = ~si;
    cs_b = 1'b1;
    #300;
  endtask
endmodule
`default_nettype wire

// ==== sim/spi_memory_status_protect_tb.sv ====
// Bench for the status and write-protect block
`timescale 1ns/10ps
`default_nettype none
module spi_memory_status_protect_tb;
  logic            clock;
  logic            rst_b;
  logic            wp_b;
  logic [10:0]     array_addr;
  logic            array_wr_req;
  wire logic       sck, cs_b, si, so, so_oe, array_wr_allow;
  wire logic [7:0] status_value;
  logic [7:0]      rd;
  int              error_cnt = 0;
  int              samples_checked = 0;
  int              cycles = 0;
  smsp_status_protect uut (.clock(clock), .rst_b(rst_b), .sck(sck),
    .cs_b(cs_b), .si(si), .wp_b(wp_b), .array_addr(array_addr),
    .array_wr_req(array_wr_req), .so(so), .so_oe(so_oe),
    .array_wr_allow(array_wr_allow), .status_value(status_value));
  smsp_host_model host (.sck(sck), .cs_b(cs_b), .si(si), .so(so));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic ws(input logic [7:0] v);
    host.frame(8'h06, 8'h00, 8, rd);
    host.frame(8'h01, v, 16, rd);
  endtask
  task automatic rs(input logic [7:0] exp);
    host.frame(8'h05, 8'ha5, 16, rd);
    chk("read status", exp, rd);
    chk("status image", exp, status_value);
    chk("output enable", 8'h00, {7'h0, so_oe});
  endtask
  task automatic req_chk(input logic [10:0] ad, input logic exp);
    @(posedge clock) #1 array_addr = ad;
    array_wr_req = 1'b1;
    repeat (2) @(posedge clock);
    #1 chk("allow", {7'h0, exp}, {7'h0, array_wr_allow});
    array_wr_req = 1'b0;
  endtask
  task automatic t_latch_gate();
    rs(8'h00);
    host.frame(8'h01, 8'h8c, 16, rd);
    rs(8'h00);
    host.frame(8'h06, 8'h00, 8, rd);
    rs(8'h02);
    rs(8'h02);
    host.frame(8'h04, 8'h00, 8, rd);
    rs(8'h00);
    host.frame(8'h06, 8'h00, 8, rd);
    host.frame(8'h01, 8'hff, 16, rd);
    rs(8'h8c);
  endtask
  task automatic t_guard();
    logic [10:0] a [4] = '{11'h3ff, 11'h400, 11'h5ff, 11'h600};
    logic        p;
    for (int g = 0; g < 4; g++) begin
      ws({4'h0, g[1:0], 2'h0});
      host.frame(8'h06, 8'h00, 8, rd);
      chk("guard", {4'h0, g[1:0], 2'h2}, status_value);
      foreach (a[i]) begin
        p = g == 3 || (g == 2 && a[i] >= 11'h400)
            || (g == 1 && a[i] >= 11'h600);
        req_chk(a[i], !p);
      end
    end
    ws(8'h00);
    req_chk(11'h000, 1'b0);
  endtask
  task automatic t_hw_guard();
    ws(8'h80);
    rs(8'h80);
    @(posedge clock) #1 wp_b = 1'b0;
    ws(8'h0c);
    rs(8'h80);
    @(posedge clock) #1 wp_b = 1'b1;
    ws(8'h0c);
    rs(8'h0c);
  endtask
  initial begin
    rst_b = 1'b0;
    wp_b = 1'b1;
    array_addr = 11'h000;
    array_wr_req = 1'b0;
    repeat (8) @(posedge clock);
    #1 rst_b = 1'b1;
    t_latch_gate();
    t_guard();
    t_hw_guard();
    stop_test();
  end
endmodule
`default_nettype wire
